// >>> verilog/fspp_pkg.sv
// Shared constants and types for the flash sector program and protect block
package fspp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  FSPP_IDX_FLASH_CONTROL_STATUS    = 8'h29;
    localparam logic [7:0]  FSPP_IDX_ADDR_LO = 8'h2A;
    localparam logic [7:0]  FSPP_IDX_ADDR_HI = 8'h2B;
    localparam logic [7:0]  FSPP_IDX_DATA    = 8'h2C;
    localparam logic [7:0]  FSPP_IDX_OPTION  = 8'h2D;
    localparam logic [7:0]  FSPP_IDX_LINK    = 8'h2E;
    localparam logic [7:0]  FSPP_IDX_STATUS  = 8'h2F;

    // flash_control_status fields
    localparam int          FSPP_FLASH_CONTROL_STATUS_PROG   = 0;
    localparam int          FSPP_FLASH_CONTROL_STATUS_SERASE = 1;
    localparam int          FSPP_FLASH_CONTROL_STATUS_BERASE = 2;
    localparam int          FSPP_FLASH_CONTROL_STATUS_READ   = 3;
    localparam int          FSPP_FLASH_CONTROL_STATUS_BUSY   = 4;
    localparam int          FSPP_FLASH_CONTROL_STATUS_DONE   = 5;
    localparam int          FSPP_FLASH_CONTROL_STATUS_REFUSE = 6;
    localparam logic [7:0]  FSPP_FLASH_CONTROL_STATUS_RESET  = 8'h00;

    // Option register field
    localparam int          FSPP_OPT_PROTECT = 0;

    // Memory size straps and sector bounds
    localparam logic [1:0]  FSPP_SIZE_4K     = 2'h0;
    localparam logic [1:0]  FSPP_SIZE_8K     = 2'h1;
    localparam logic [1:0]  FSPP_SIZE_32K    = 2'h2;
    localparam logic [1:0]  FSPP_SIZE_60K    = 2'h3;
    localparam logic [15:0] FSPP_SECT0_BASE  = 16'hF000;
    localparam logic [15:0] FSPP_SECT1_BASE  = 16'hE000;
    localparam logic [15:0] FSPP_BASE_32K    = 16'h8000;
    localparam logic [15:0] FSPP_BASE_60K    = 16'h1000;
    localparam logic [1:0]  FSPP_SECT_NONE   = 2'h3;

    localparam logic [2:0]  FSPP_BIT_LAST    = 3'h7;

    typedef enum logic [1:0] {
        FSPP_OP_READ,
        FSPP_OP_PROG,
        FSPP_OP_SERASE,
        FSPP_OP_BERASE
    } fspp_op_t;

    // Request to the flash array macro
    typedef struct packed {
        logic       req;
        fspp_op_t   op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fspp_arr_req_t;

    // Answer of the flash array macro
    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
    } fspp_arr_rsp_t;

    // Device-side pin drive toward the serial link pins
    typedef struct packed {
        logic       data_o;
        logic       data_oe_n;
        logic       clk_o;
        logic       clk_oe_n;
    } fspp_pins_t;

endpackage

// >>> verilog/fspp_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module fspp_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule
`default_nettype wire

// >>> verilog/fspp_top.sv
// Flash program/erase controller with sector protection, read-out guard and serial link
`timescale 1ns/10ps
`default_nettype none
module fspp_top
    import fspp_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Flash array macro
    output fspp_arr_req_t      arr_req,
    input  wire fspp_arr_rsp_t arr_rsp,
    // Straps caught after reset release
    input  wire logic [1:0]    mem_size_strap,
    input  wire logic          protect_strap,
    input  wire logic          mask_variant_strap,
    // Serial link pins
    input  wire logic          serial_prog_clock_i,
    input  wire logic          serial_prog_data_i,
    output logic               serial_prog_data_o,
    output logic               serial_prog_data_oe_n,
    output logic               serial_prog_clock_o,
    output logic               serial_prog_clock_oe_n,
    input  wire logic          prog_select_voltage,
    // Application side of the shared pins
    input  wire logic          app_data_o,
    input  wire logic          app_data_oe_n,
    input  wire logic          app_clk_o,
    input  wire logic          app_clk_oe_n,
    output logic               app_data_i,
    output logic               app_clk_i,
    output logic               tool_attached,
    // Supervisor gating
    input  wire logic          low_voltage_detector_req,
    output logic               low_voltage_detector_en
);

    typedef enum logic [1:0] {
        FSPP_ST_BOOT,
        FSPP_ST_IDLE,
        FSPP_ST_WAIT
    } fspp_state_t;

    typedef struct packed {
        fspp_state_t   st;
        logic          ack;
        logic [7:0]    rdata;
        logic [7:0]    flash_control_status;
        logic [15:0]   addr;
        logic [7:0]    data;
        logic          protect;
        logic          mask_var;
        logic [1:0]    size;
        logic          unprot;
        fspp_arr_req_t arr;
        logic          sclk_prev;
        logic [7:0]    rx_sh;
        logic [2:0]    bit_cnt;
        logic [7:0]    rx_byte;
        logic          rx_full;
        logic [7:0]    tx_sh;
        logic          tx_drive;
        fspp_pins_t    pins;
        logic          app_data_i;
        logic          app_clk_i;
    } fspp_regs_t;

    fspp_regs_t  s_reg;
    fspp_regs_t  s_next;
    logic [2:0]  pin_sync;
    logic        sclk_s;
    logic        sdata_s;
    logic        tool_s;

    fspp_sync #(.W(3)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({serial_prog_clock_i, serial_prog_data_i, prog_select_voltage}),
        .sync_out (pin_sync)
    );
    assign sclk_s  = pin_sync[2];
    assign sdata_s = pin_sync[1];
    assign tool_s  = pin_sync[0];

    // Lowest array address for a size strap
    function automatic logic [15:0] array_base(input logic [1:0] size);
        unique case (size)
            FSPP_SIZE_4K:  array_base = FSPP_SECT0_BASE;
            FSPP_SIZE_8K:  array_base = FSPP_SECT1_BASE;
            FSPP_SIZE_32K: array_base = FSPP_BASE_32K;
            FSPP_SIZE_60K: array_base = FSPP_BASE_60K;
        endcase
    endfunction

    // Sector holding an address, or none outside the array
    function automatic logic [1:0] sector_of(input logic [15:0] a, input logic [1:0] size);
        if (a >= FSPP_SECT0_BASE)
            sector_of = 2'h0;
        else if (a < array_base(size))
            sector_of = FSPP_SECT_NONE;
        else if (a >= FSPP_SECT1_BASE)
            sector_of = 2'h1;
        else
            sector_of = 2'h2;
    endfunction

    // Whether a request may reach the array
    function automatic logic op_allowed(input fspp_op_t op, input logic [15:0] a,
                                        input logic [1:0] size, input logic tool,
                                        input logic prot);
        logic [1:0] sect;
        sect = sector_of(a, size);
        op_allowed = 1'b1;
        if (op != FSPP_OP_BERASE && sect == FSPP_SECT_NONE)
            op_allowed = 1'b0;
        if (op == FSPP_OP_READ && prot && tool)
            op_allowed = 1'b0;
        if (op != FSPP_OP_READ && prot)
            op_allowed = 1'b0;
        if (op == FSPP_OP_BERASE && !tool)
            op_allowed = 1'b0;
        if (op != FSPP_OP_READ && !tool && sect == 2'h0)
            op_allowed = 1'b0;
    endfunction

    logic        acc;
    logic        wr_go;
    logic [7:0]  idx;
    logic        hit;
    logic [7:0]  rd_mux;
    logic        start;
    fspp_op_t    start_op;
    logic        sclk_rise;

    always_comb begin
        acc       = psel && penable && !s_reg.ack;
        wr_go     = psel && penable && s_reg.ack && pwrite;
        idx       = paddr[9:2];
        hit       = (paddr[11:10] == 2'h0) && (idx >= FSPP_IDX_FLASH_CONTROL_STATUS) && (idx <= FSPP_IDX_STATUS);
        sclk_rise = sclk_s && !s_reg.sclk_prev;
        unique case (idx)
            FSPP_IDX_FLASH_CONTROL_STATUS:    rd_mux = s_reg.flash_control_status;
            FSPP_IDX_ADDR_LO: rd_mux = s_reg.addr[7:0];
            FSPP_IDX_ADDR_HI: rd_mux = s_reg.addr[15:8];
            FSPP_IDX_DATA:    rd_mux = s_reg.data;
            FSPP_IDX_OPTION:  rd_mux = {7'h00, s_reg.protect};
            FSPP_IDX_LINK:    rd_mux = s_reg.rx_byte;
            FSPP_IDX_STATUS:  rd_mux = {3'h0, s_reg.size, s_reg.mask_var, s_reg.rx_full, tool_s};
            default:          rd_mux = 8'h00;
        endcase
        start    = 1'b0;
        start_op = FSPP_OP_READ;
        if (wr_go && hit && idx == FSPP_IDX_FLASH_CONTROL_STATUS) begin
            if (pwdata[FSPP_FLASH_CONTROL_STATUS_PROG]) begin
                start    = 1'b1;
                start_op = FSPP_OP_PROG;
            end else if (pwdata[FSPP_FLASH_CONTROL_STATUS_SERASE]) begin
                start    = 1'b1;
                start_op = FSPP_OP_SERASE;
            end else if (pwdata[FSPP_FLASH_CONTROL_STATUS_BERASE]) begin
                start    = 1'b1;
                start_op = FSPP_OP_BERASE;
            end else if (pwdata[FSPP_FLASH_CONTROL_STATUS_READ]) begin
                start    = 1'b1;
            end
        end
    end

    always_comb begin
        s_next     = s_reg;
        s_next.ack = acc;
        if (acc)
            s_next.rdata = hit ? rd_mux : 8'h00;
        s_next.sclk_prev = sclk_s;

        // Plain register writes
        if (wr_go && hit) begin
            unique case (idx)
                FSPP_IDX_FLASH_CONTROL_STATUS: begin
                    if (pwdata[FSPP_FLASH_CONTROL_STATUS_DONE])
                        s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_DONE] = 1'b0;
                    if (pwdata[FSPP_FLASH_CONTROL_STATUS_REFUSE])
                        s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_REFUSE] = 1'b0;
                end
                FSPP_IDX_ADDR_LO: s_next.addr[7:0]  = pwdata[7:0];
                FSPP_IDX_ADDR_HI: s_next.addr[15:8] = pwdata[7:0];
                FSPP_IDX_DATA:    s_next.data       = pwdata[7:0];
                FSPP_IDX_OPTION: begin
                    // Option byte changes only from the tool and never on mask parts
                    if (tool_s && !s_reg.mask_var && s_reg.st == FSPP_ST_IDLE) begin
                        if (pwdata[FSPP_OPT_PROTECT])
                            s_next.protect = 1'b1;
                        else if (s_reg.protect)
                            s_next.unprot = 1'b1;
                    end
                end
                FSPP_IDX_LINK: begin
                    if (tool_s) begin
                        s_next.tx_sh    = pwdata[7:0];
                        s_next.tx_drive = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (acc && !pwrite && hit && idx == FSPP_IDX_LINK)
            s_next.rx_full = 1'b0;

        unique case (s_reg.st)
            FSPP_ST_BOOT: begin
                s_next.size     = mem_size_strap;
                s_next.protect  = protect_strap;
                s_next.mask_var = mask_variant_strap;
                s_next.st       = FSPP_ST_IDLE;
            end
            FSPP_ST_IDLE: begin
                if (s_reg.unprot) begin
                    // Full erase comes before protection is dropped
                    s_next.arr.req   = 1'b1;
                    s_next.arr.op    = FSPP_OP_BERASE;
                    s_next.arr.addr  = array_base(s_reg.size);
                    s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_BUSY] = 1'b1;
                    s_next.st        = FSPP_ST_WAIT;
                end else if (start) begin
                    if (op_allowed(start_op, s_reg.addr, s_reg.size, tool_s, s_reg.protect)) begin
                        s_next.arr.req   = 1'b1;
                        s_next.arr.op    = start_op;
                        s_next.arr.addr  = (start_op == FSPP_OP_BERASE) ?
                                           array_base(s_reg.size) : s_reg.addr;
                        s_next.arr.wdata = s_reg.data;
                        s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_BUSY] = 1'b1;
                        s_next.st        = FSPP_ST_WAIT;
                    end else begin
                        s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_REFUSE] = 1'b1;
                    end
                end
            end
            FSPP_ST_WAIT: begin
                if (arr_rsp.done) begin
                    s_next.arr.req = 1'b0;
                    s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_BUSY] = 1'b0;
                    s_next.flash_control_status[FSPP_FLASH_CONTROL_STATUS_DONE] = 1'b1;
                    if (s_reg.arr.op == FSPP_OP_READ)
                        s_next.data = arr_rsp.rdata;
                    if (s_reg.unprot) begin
                        s_next.unprot  = 1'b0;
                        s_next.protect = 1'b0;
                    end
                    s_next.st = FSPP_ST_IDLE;
                end
            end
        endcase

        // Serial link, sampled and shifted on tool clock rises
        if (!tool_s) begin
            s_next.bit_cnt  = 3'h0;
            s_next.tx_drive = 1'b0;
        end else if (sclk_rise) begin
            s_next.rx_sh   = {s_reg.rx_sh[6:0], sdata_s};
            s_next.tx_sh   = {s_reg.tx_sh[6:0], 1'b0};
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == FSPP_BIT_LAST) begin
                s_next.rx_byte  = {s_reg.rx_sh[6:0], sdata_s};
                s_next.rx_full  = 1'b1;
                s_next.tx_drive = 1'b0;
            end
        end

        // Shared pins go to the tool while it is attached
        s_next.pins.data_o    = tool_s ? s_reg.tx_sh[7] : app_data_o;
        s_next.pins.data_oe_n = tool_s ? !s_next.tx_drive : app_data_oe_n;
        s_next.pins.clk_o     = app_clk_o;
        s_next.pins.clk_oe_n  = tool_s ? 1'b1 : app_clk_oe_n;
        s_next.app_data_i     = tool_s ? 1'b0 : sdata_s;
        s_next.app_clk_i      = tool_s ? 1'b0 : sclk_s;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg            <= '0;
            s_reg.st         <= FSPP_ST_BOOT;
            s_reg.flash_control_status       <= FSPP_FLASH_CONTROL_STATUS_RESET;
            s_reg.pins       <= '{data_o: 1'b0, data_oe_n: 1'b1, clk_o: 1'b0, clk_oe_n: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata                  = {24'h000000, s_reg.rdata};
    assign pready                  = psel && penable && s_reg.ack;
    assign pslverr                 = pready && !hit;
    assign arr_req                 = s_reg.arr;
    assign serial_prog_data_o      = s_reg.pins.data_o;
    assign serial_prog_data_oe_n   = s_reg.pins.data_oe_n;
    assign serial_prog_clock_o     = s_reg.pins.clk_o;
    assign serial_prog_clock_oe_n  = s_reg.pins.clk_oe_n;
    assign app_data_i              = s_reg.app_data_i;
    assign app_clk_i               = s_reg.app_clk_i;
    assign tool_attached           = tool_s;
    assign low_voltage_detector_en = low_voltage_detector_req && !s_reg.protect;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sect0_iap_guard_a: assert property (
        $rose(s_reg.arr.req) && !$past(tool_s) && s_reg.arr.op != FSPP_OP_READ
        |-> sector_of(s_reg.arr.addr, s_reg.size) != 2'h0 && s_reg.arr.op != FSPP_OP_BERASE)
        else $error("sector 0 changed outside tool mode");

    protect_write_a: assert property (
        $rose(s_reg.arr.req) && s_reg.arr.op != FSPP_OP_READ
        |-> !s_reg.protect || s_reg.unprot)
        else $error("array write while read-out protected");

    readout_block_a: assert property (
        $rose(s_reg.arr.req) && s_reg.arr.op == FSPP_OP_READ
        |-> !($past(tool_s) && s_reg.protect))
        else $error("external read while protected");

    unprot_erase_a: assert property (
        $fell(s_reg.protect) |-> $past(arr_rsp.done) && $past(s_reg.arr.op) == FSPP_OP_BERASE)
        else $error("protection dropped without full erase");

    lvd_gate_a: assert property (
        s_reg.protect |-> !low_voltage_detector_en)
        else $error("voltage detector on while protected");

    pins_taken_a: assert property (
        tool_s ##1 tool_s |-> !app_data_i && !app_clk_i && serial_prog_clock_oe_n)
        else $error("link pins leaked to application");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("register answer late");

    refuse_quiet_a: assert property (
        $rose(s_reg.flash_control_status[FSPP_FLASH_CONTROL_STATUS_REFUSE]) |-> !$rose(s_reg.arr.req) && s_reg.st != FSPP_ST_WAIT)
        else $error("refused request reached array");

    small_array_a: assert property (
        s_reg.arr.req && s_reg.size == FSPP_SIZE_4K |-> s_reg.arr.addr >= FSPP_SECT0_BASE)
        else $error("access outside single-sector array");

endmodule
`default_nettype wire

// >>> bench/fspp_array_model.sv
// Behavioural flash array macro answering the controller's requests
`timescale 1ns/10ps
`default_nettype none
module fspp_array_model
    import fspp_pkg::*;
#(
    parameter int          LAT  = 3,
    parameter logic [15:0] BASE = 16'h8000
) (
    // Clock
    input  wire logic          pclk,
    // Request and answer
    input  wire fspp_arr_req_t arr_req,
    output fspp_arr_rsp_t      arr_rsp
);
    logic [7:0] mem [0:65535];
    int         cnt;
    int         lo;
    int         hi;

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        arr_rsp = '0;
        cnt = 0;
    end

    // One done pulse per request, then wait for req to drop
    always @(posedge pclk) begin
        arr_rsp.done <= 1'b0;
        if (!arr_req.req) begin
            cnt <= 0;
        end else if (cnt < LAT) begin
            cnt <= cnt + 1;
        end else if (cnt == LAT) begin
            cnt <= cnt + 1;
            arr_rsp.done <= 1'b1;
            lo = {arr_req.addr[15:12], 12'h000};
            hi = lo + 4095;
            if (arr_req.addr < 16'hE000) begin
                lo = BASE;
                hi = 16'hDFFF;
            end
            case (arr_req.op)
                FSPP_OP_READ:   arr_rsp.rdata <= mem[arr_req.addr];
                FSPP_OP_PROG:   mem[arr_req.addr] = arr_req.wdata;
                FSPP_OP_SERASE: for (int a = lo; a <= hi; a++) mem[a] = 8'hFF;
                default:        for (int a = BASE; a <= 65535; a++) mem[a] = 8'hFF;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Register-level testbench for the flash program and protect controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import fspp_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, err;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          pready, pslverr, sck, sdi, psv, lvd_req, lvd_en, tool, app_di;
    logic          sdo, sdoe_n;
    logic [1:0]    size;
    logic          mask;
    fspp_arr_req_t arr_req;
    fspp_arr_rsp_t arr_rsp;
    int            failures, total_checks, cycles;

    fspp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arr_req(arr_req), .arr_rsp(arr_rsp), .mem_size_strap(size),
        .protect_strap(1'b0), .mask_variant_strap(mask), .serial_prog_clock_i(sck),
        .serial_prog_data_i(sdi), .serial_prog_data_o(sdo), .serial_prog_data_oe_n(sdoe_n),
        .serial_prog_clock_o(), .serial_prog_clock_oe_n(), .prog_select_voltage(psv),
        .app_data_o(1'b0), .app_data_oe_n(1'b1), .app_clk_o(1'b0), .app_clk_oe_n(1'b1),
        .app_data_i(app_di), .app_clk_i(), .tool_attached(tool),
        .low_voltage_detector_req(lvd_req), .low_voltage_detector_en(lvd_en));
    fspp_array_model model (.pclk(pclk), .arr_req(arr_req), .arr_rsp(arr_rsp));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; read data and error kept in rd and err
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 100; k++) begin
            apb(1'b0, FSPP_IDX_FLASH_CONTROL_STATUS, 8'h00);
            if (rd[FSPP_FLASH_CONTROL_STATUS_BUSY] === 1'b0) break;
        end
    endtask

    // Load address and data, clear sticky flags, start, wait for idle
    task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] cmd);
        apb(1'b1, FSPP_IDX_ADDR_LO, a[7:0]);
        apb(1'b1, FSPP_IDX_ADDR_HI, a[15:8]);
        apb(1'b1, FSPP_IDX_DATA, d);
        apb(1'b1, FSPP_IDX_FLASH_CONTROL_STATUS, 8'h60);
        apb(1'b1, FSPP_IDX_FLASH_CONTROL_STATUS, cmd);
        wait_idle();
    endtask

    // Tool frame, MSB first, link clock at 125 ns
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sdi <= b[i];
            #62.5 sck <= 1'b1;
            #62.5 sck <= 1'b0;
        end
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, sck, sdi, psv, mask} = '0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        lvd_req = 1'b1;
        size = FSPP_SIZE_32K;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, FSPP_IDX_FLASH_CONTROL_STATUS, 8'h00);
        check(rd[7:0], FSPP_FLASH_CONTROL_STATUS_RESET);
        apb(1'b0, 8'h10, 8'h00);
        check({7'h00, err}, 8'h01);
        check({7'h00, lvd_en}, 8'h01);
        op(16'hE010, 8'h5A, 8'h01);
        check(rd[7:0], 8'h20);
        check(model.mem[16'hE010], 8'h5A);
        op(16'hE010, 8'h00, 8'h08);
        apb(1'b0, FSPP_IDX_DATA, 8'h00);
        check(rd[7:0], 8'h5A);
        op(16'hF010, 8'h11, 8'h01);
        check(rd[7:0], 8'h40);
        check(model.mem[16'hF010], 8'hFF);
        op(16'hE000, 8'h00, 8'h04);
        check(rd[7:0], 8'h40);
        check(model.mem[16'hE010], 8'h5A);
        psv <= 1'b1;
        sdi <= 1'b1;
        repeat (5) @(posedge pclk);
        check({7'h00, tool}, 8'h01);
        check({7'h00, app_di}, 8'h00);
        apb(1'b1, FSPP_IDX_LINK, 8'h80);
        repeat (2) @(posedge pclk);
        check({7'h00, sdoe_n}, 8'h00);
        check({7'h00, sdo}, 8'h01);
        send(8'hA5);
        repeat (5) @(posedge pclk);
        check({7'h00, sdoe_n}, 8'h01);
        check({7'h00, sdo}, 8'h00);
        apb(1'b0, FSPP_IDX_LINK, 8'h00);
        check(rd[7:0], 8'hA5);
        op(16'hF010, 8'hC3, 8'h01);
        check(rd[7:0], 8'h20);
        check(model.mem[16'hF010], 8'hC3);
        op(16'hE020, 8'h00, 8'h02);
        check(model.mem[16'hE010], 8'hFF);
        check(model.mem[16'hF010], 8'hC3);
        apb(1'b1, FSPP_IDX_OPTION, 8'h01);
        apb(1'b0, FSPP_IDX_OPTION, 8'h00);
        check(rd[7:0], 8'h01);
        check({7'h00, lvd_en}, 8'h00);
        op(16'hE030, 8'h77, 8'h01);
        check(rd[7:0], 8'h40);
        apb(1'b1, FSPP_IDX_OPTION, 8'h00);
        wait_idle();
        check(model.mem[16'hF010], 8'hFF);
        apb(1'b0, FSPP_IDX_OPTION, 8'h00);
        check(rd[7:0], 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
